// ---- pkg/utd_pkg.sv ----
// package for the transmit dma control register block
package utd_pkg;

  // register byte offsets (no offsets printed; chosen locally)
  localparam logic [7:0] OFF_INT_VECTOR   = 8'h00;
  localparam logic [7:0] OFF_CONTROL      = 8'h04;
  localparam logic [7:0] OFF_TEARDOWN     = 8'h08;
  localparam logic [7:0] OFF_EOI          = 8'h0c;
  localparam logic [7:0] OFF_MASKED_STAT  = 8'h10;
  localparam logic [7:0] OFF_RAW_STAT     = 8'h14;
  localparam logic [7:0] OFF_IEN_SET      = 8'h18;
  localparam logic [7:0] OFF_IEN_CLEAR    = 8'h1c;
  localparam logic [7:0] OFF_RAW_CLEAR    = 8'h20;

  // field positions and channel count
  localparam int TD_READY_BIT  = 31;
  localparam int CTRL_ON_BIT   = 0;
  localparam int NUM_CHANNELS  = 4;

  // reset values
  localparam logic       RST_DMA_ON   = 1'b0;
  localparam logic [3:0] RST_ENABLES  = 4'h0;
  localparam logic [3:0] RST_RAW      = 4'h0;
  localparam logic [7:0] RST_EOI      = 8'h00;
  localparam logic [1:0] RST_TD_CHAN  = 2'h0;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } utd_bus_req_t;

  // teardown request handed to the dma engine
  typedef struct packed {
    logic       valid;
    logic [1:0] channel;
  } utd_teardown_t;

endpackage

// ---- src/utd_regs.sv ----
// register block for the transmit dma control, teardown, eoi and completion status
//
// Function
// - read-only 32-bit register mirrors the interrupt vector input
// - control bit 0 enables transmit dma; other bits reserved
// - teardown bit 31 shows readiness; software writes only when ready
// - teardown bits 1:0 select channel to tear down
// - eoi write puts 8-bit value on vector output next cycle
// - each eoi write pulses eoi strobe for exactly one cycle
// - eoi strobe is output only; a still-pending source keeps tx_irq high as a level
// - raw status bits 3:0 set when channel packet transmit completes
// - masked status equals raw flags AND interrupt enables
// - four active-high completion interrupt enables, one per channel
// - enable-clear write of one clears the matching enable
`timescale 1ns/1ps
module utd_regs
  import utd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata,
  // core side
  input  wire logic [31:0] int_vector,
  input  wire logic [3:0]  tx_done,
  input  wire logic        td_accept,
  output      logic        tx_dma_on,
  output      logic        td_valid,
  output      logic [1:0]  td_channel,
  output      logic [7:0]  eoi_vector,
  output      logic        eoi_write,
  output      logic        tx_irq
);

  utd_bus_req_t  req;
  utd_teardown_t td_reg, td_next;
  logic          on_reg, on_next;
  logic [3:0]    ien_reg, ien_next;
  logic [3:0]    raw_reg, raw_next;
  logic [7:0]    eoi_reg, eoi_next;
  logic          eoiw_reg, eoiw_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic [3:0]    masked;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign masked = raw_reg & ien_reg;

  // transmit dma enable
  always_comb begin
    on_next = on_reg;
    if (req.wr && req.addr == OFF_CONTROL) begin
      on_next = req.wdata[CTRL_ON_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg <= RST_DMA_ON;
    end else begin
      on_reg <= on_next;
    end
  end

  a_dma_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_CONTROL
    |=> tx_dma_on == $past(reg_wdata[0]))
    else $error("dma enable not written");
  a_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFF_CONTROL)
    |=> $stable(tx_dma_on))
    else $error("dma enable changed without write");
  a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_CONTROL
    |=> reg_rdata[0] == $past(tx_dma_on))
    else $error("control read wrong");
  a_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_CONTROL
    |=> reg_rdata[31:1] == 31'h0)
    else $error("control reserved bits not zero");

  // teardown: one pending request, cleared when the engine accepts it
  always_comb begin
    td_next = td_reg;
    if (td_reg.valid && td_accept) begin
      td_next.valid = 1'b0;
    end
    // writes while busy are dropped so a pending request is not lost
    if (req.wr && req.addr == OFF_TEARDOWN && !td_reg.valid) begin
      td_next.valid   = 1'b1;
      td_next.channel = req.wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      td_reg <= '{valid: 1'b0, channel: RST_TD_CHAN};
    end else begin
      td_reg <= td_next;
    end
  end

  a_td_ready_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_TEARDOWN
    |=> reg_rdata[31] == !$past(td_valid))
    else $error("teardown ready wrong");
  a_td_channel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_TEARDOWN && !td_valid
    |=> td_valid && td_channel == $past(reg_wdata[1:0]))
    else $error("teardown channel wrong");
  a_td_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_TEARDOWN && td_valid && !td_accept
    |=> td_valid && $stable(td_channel))
    else $error("busy teardown write not refused");
  a_td_accept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    td_valid && td_accept
    |=> !td_valid)
    else $error("accepted teardown still pending");
  a_td_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    td_valid && !td_accept
    |=> td_valid)
    else $error("pending teardown lost");
  a_td_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !td_valid && !(reg_wr && reg_addr == OFF_TEARDOWN)
    |=> !td_valid)
    else $error("teardown raised without write");
  a_td_chan_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_TEARDOWN
    |=> reg_rdata[1:0] == $past(td_channel))
    else $error("teardown channel read wrong");
  a_td_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_TEARDOWN
    |=> reg_rdata[30:2] == 29'h0)
    else $error("teardown reserved bits not zero");
  a_td_chan_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFF_TEARDOWN)
    |=> $stable(td_channel))
    else $error("teardown channel changed without write");

  // end of interrupt: vector register and one-cycle strobe
  always_comb begin
    eoi_next  = eoi_reg;
    eoiw_next = 1'b0;
    if (req.wr && req.addr == OFF_EOI) begin
      eoi_next  = req.wdata[7:0];
      eoiw_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eoi_reg  <= RST_EOI;
      eoiw_reg <= 1'b0;
    end else begin
      eoi_reg  <= eoi_next;
      eoiw_reg <= eoiw_next;
    end
  end

  a_eoi_vec_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_EOI
    |=> eoi_vector == $past(reg_wdata[7:0]))
    else $error("eoi vector not updated");
  a_eoi_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_EOI ##1 !(reg_wr && reg_addr == OFF_EOI)
    |=> !eoi_write)
    else $error("eoi strobe too long");
  a_eoi_pulse_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    eoi_write
    |-> $past(reg_wr) && $past(reg_addr) == OFF_EOI)
    else $error("eoi strobe without write");
  a_eoi_vec_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFF_EOI)
    |=> $stable(eoi_vector))
    else $error("eoi vector changed without write");
  a_eoi_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_EOI
    |=> eoi_write)
    else $error("eoi strobe missing");
  a_eoi_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_EOI
    |=> reg_rdata[7:0] == $past(eoi_vector))
    else $error("eoi read wrong");
  a_eoi_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_EOI
    |=> reg_rdata[31:8] == 24'h0)
    else $error("eoi reserved bits not zero");
  a_eoi_no_repeat: assert property (@(posedge ref_clk) disable iff (!rst_n)
    eoi_write
    |=> !eoi_write || $past(reg_wr && reg_addr == OFF_EOI))
    else $error("eoi strobe repeated");

  // completion interrupt enables, written through set and clear addresses
  always_comb begin
    ien_next = ien_reg;
    if (req.wr && req.addr == OFF_IEN_SET) begin
      ien_next = ien_reg | req.wdata[3:0];
    end
    if (req.wr && req.addr == OFF_IEN_CLEAR) begin
      ien_next = ien_reg & ~req.wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_reg <= RST_ENABLES;
    end else begin
      ien_reg <= ien_next;
    end
  end

  a_ien_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_IEN_SET
    |=> ien_reg == ($past(ien_reg) | $past(reg_wdata[3:0])))
    else $error("enable set wrong");
  a_ien_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_IEN_CLEAR
    |=> ien_reg == ($past(ien_reg) & ~$past(reg_wdata[3:0])))
    else $error("enable clear wrong");
  a_ien_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && (reg_addr == OFF_IEN_SET || reg_addr == OFF_IEN_CLEAR))
    |=> $stable(ien_reg))
    else $error("enables changed without write");
  a_ien_read_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_IEN_SET
    |=> reg_rdata == {28'h0, $past(ien_reg)})
    else $error("enable read wrong");
  a_ien_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_IEN_CLEAR
    |=> reg_rdata == {28'h0, $past(ien_reg)})
    else $error("enable read through clear wrong");

  // raw completion flags
  always_comb begin
    raw_next = raw_reg;
    if (req.wr && req.addr == OFF_RAW_CLEAR) begin
      raw_next = raw_reg & ~req.wdata[3:0];
    end
    // completion sets win over a same-cycle clear
    raw_next = raw_next | tx_done;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= RST_RAW;
    end else begin
      raw_reg <= raw_next;
    end
  end

  a_raw_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_done != 4'h0
    |=> (raw_reg & $past(tx_done)) == $past(tx_done))
    else $error("raw flag not set");
  a_raw_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFF_RAW_CLEAR)
    |=> (raw_reg & $past(raw_reg)) == $past(raw_reg))
    else $error("raw flag lost");
  a_raw_only_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_done == 4'h0
    |=> (raw_reg & ~$past(raw_reg)) == 4'h0)
    else $error("raw flag set without completion");
  a_raw_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_RAW_STAT
    |=> reg_rdata == {28'h0, $past(raw_reg)})
    else $error("raw status read wrong");
  a_raw_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_RAW_CLEAR && tx_done == 4'h0
    |=> raw_reg == ($past(raw_reg) & ~$past(reg_wdata[3:0])))
    else $error("raw clear wrong");

  // read data: registered, zero outside the cycle after a read
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.addr)
        OFF_INT_VECTOR:  rdata_next = int_vector;
        OFF_CONTROL:     rdata_next = {31'h0, on_reg};
        OFF_TEARDOWN:    rdata_next = {~td_reg.valid, 29'h0, td_reg.channel};
        OFF_EOI:         rdata_next = {24'h0, eoi_reg};
        OFF_MASKED_STAT: rdata_next = {28'h0, masked};
        OFF_RAW_STAT:    rdata_next = {28'h0, raw_reg};
        OFF_IEN_SET:     rdata_next = {28'h0, ien_reg};
        OFF_IEN_CLEAR:   rdata_next = {28'h0, ien_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  a_vec_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_INT_VECTOR
    |=> reg_rdata == $past(int_vector))
    else $error("vector read wrong");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd
    |=> reg_rdata == 32'h0000_0000)
    else $error("read data without read");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr > OFF_RAW_CLEAR
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  assign reg_rdata  = rdata_reg;
  assign tx_dma_on  = on_reg;
  assign td_valid   = td_reg.valid;
  assign td_channel = td_reg.channel;
  assign eoi_vector = eoi_reg;
  assign eoi_write  = eoiw_reg;
  assign tx_irq     = |masked;

  a_masked_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_MASKED_STAT
    |=> reg_rdata == {28'h0, $past(raw_reg) & $past(ien_reg)})
    else $error("masked status wrong");
  a_masked_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_MASKED_STAT
    |=> reg_rdata[31:4] == 28'h0)
    else $error("masked reserved bits not zero");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1
    |-> tx_irq == |(raw_reg & ien_reg))
    else $error("irq level wrong");
  a_irq_masked_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ien_reg == 4'h0
    |-> !tx_irq)
    else $error("irq with all enables off");

  c_eoi_write: cover property (@(posedge ref_clk) disable iff (!rst_n) eoi_write);
  c_teardown: cover property (@(posedge ref_clk) disable iff (!rst_n) td_valid ##[1:20] !td_valid);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) tx_irq ##[1:50] !tx_irq);
  c_td_refused: cover property (@(posedge ref_clk) disable iff (!rst_n) reg_wr && reg_addr == OFF_TEARDOWN && td_valid);
  c_raw_collide: cover property (@(posedge ref_clk) disable iff (!rst_n) reg_wr && reg_addr == OFF_RAW_CLEAR && tx_done != 4'h0);

endmodule // utd_regs

// ---- tb/tb_top.sv ----
// self-checking testbench for the transmit dma control register block
`timescale 1ns/1ps
module tb_top;
  import utd_pkg::*;
  logic        ref_clk, rst_n, reg_wr, reg_rd, td_accept, tx_dma_on, td_valid, eoi_write, tx_irq;
  logic [7:0]  reg_addr, eoi_vector;
  logic [31:0] reg_wdata, reg_rdata, int_vector, d, v;
  logic [3:0]  tx_done, en, raw;
  logic [1:0]  td_channel;
  int          err_count, n_checks, cyc;
  utd_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_vector(int_vector), .tx_done(tx_done),
    .td_accept(td_accept), .tx_dma_on(tx_dma_on), .td_valid(td_valid), .td_channel(td_channel),
    .eoi_vector(eoi_vector), .eoi_write(eoi_write), .tx_irq(tx_irq));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] masked(input logic [3:0] r, input logic [3:0] e);
    return {28'h0, r & e};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, td_accept, reg_addr, reg_wdata, int_vector, tx_done} = '0;
    v = $urandom(34525);
    en = 4'h0;
    raw = 4'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_TEARDOWN);
    chk("teardown ready", 32'h8000_0000, d);
    for (int i = 0; i < 4; i++) begin
      int_vector <= $urandom;
      rd(OFF_INT_VECTOR);
      chk("vector", int_vector, d);
      v = $urandom;
      wr(OFF_CONTROL, v);
      chk("dma on", {31'h0, v[0]}, {31'h0, tx_dma_on});
      rd(OFF_CONTROL);
      chk("control", {31'h0, v[0]}, d);
      wr(OFF_TEARDOWN, 32'(i));
      chk("td request", {29'h0, 1'b1, 2'(i)}, {29'h0, td_valid, td_channel});
      rd(OFF_TEARDOWN);
      chk("teardown busy", 32'(i), d);
      wr(OFF_TEARDOWN, 32'(3 - i));
      chk("td refused", 32'(i), {30'h0, td_channel});
      @(posedge ref_clk);
      td_accept <= 1'b1;
      @(posedge ref_clk);
      td_accept <= 1'b0;
      #1 chk("td done", 32'h0, {31'h0, td_valid});
    end
    $display("test control and teardown done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(OFF_EOI, v);
      chk("eoi vector", {24'h0, v[7:0]}, {24'h0, eoi_vector});
      chk("eoi strobe", 32'h1, {31'h0, eoi_write});
      wr(OFF_EOI, ~v);
      chk("eoi again", {23'h0, 1'b1, ~v[7:0]}, {23'h0, eoi_write, eoi_vector});
      @(posedge ref_clk);
      #1 chk("eoi strobe low", 32'h0, {31'h0, eoi_write});
    end
    $display("test end of interrupt done");
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $urandom;
      en = en | v[3:0];
      wr(OFF_IEN_SET, v);
      v = (i == 11) ? 32'hffff_fff0 : $urandom;
      en = en & ~v[3:0];
      wr(OFF_IEN_CLEAR, v);
      rd(OFF_IEN_SET);
      chk("enables", {28'h0, en}, d);
      v = $urandom;
      @(posedge ref_clk);
      tx_done <= v[3:0];
      @(posedge ref_clk);
      tx_done <= 4'h0;
      raw = raw | v[3:0];
      rd(OFF_RAW_STAT);
      chk("raw", {28'h0, raw}, d);
      rd(OFF_MASKED_STAT);
      chk("masked", masked(raw, en), d);
      chk("irq", {31'h0, |(raw & en)}, {31'h0, tx_irq});
      v = $urandom;
      raw = raw & ~v[3:0];
      wr(OFF_RAW_CLEAR, v);
    end
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    $display("test completion status done");
    complete_run();
  end
endmodule // tb_top
